// >>> adc_pm_pkg.sv
// Package with constants, modes and carrier types for the converter power sequencer.
`default_nettype none
package adc_pm_pkg;
   // Power mode encodings carried by the two mode bits.
   localparam logic [1:0] PM_NORMAL      = 2'h0;
   localparam logic [1:0] PM_FULL_AFTER  = 2'h1;
   localparam logic [1:0] PM_FULL_NOW    = 2'h2;
   localparam logic [1:0] PM_PART_AFTER  = 2'h3;
   localparam logic [1:0] PM_RESET_VAL   = 2'h0;
   localparam int unsigned CONTROL_MODE_LOW_POS  = 0;
   localparam int unsigned CONTROL_MODE_HIGH_POS = 1;

   // Timing in its own unit and the derived cycle counts at 100 MHz.
   localparam int unsigned CLK_PERIOD_NS    = 10;
   localparam int unsigned WAKE_TIME_NS     = 5000;
   localparam int unsigned WAKE_CYCLES      = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TIMEOUT_TIME_US  = 32000;
   localparam int unsigned TIMEOUT_CYCLES   = TIMEOUT_TIME_US * (1000 / CLK_PERIOD_NS);
   localparam int unsigned CONV_TIME_NS     = 4600;
   localparam int unsigned CONV_CYCLES      = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned CNT_W            = 32;

   // Sequencer states.
   typedef enum logic [2:0] {
      ST_WAIT_FIRST,
      ST_TIMEOUT,
      ST_WAIT_CAL,
      ST_CAL,
      ST_IDLE,
      ST_WAKE,
      ST_CONVERT,
      ST_DOWN
   } seq_state_t;

   // Power-rail enables that leave the block.
   typedef struct packed {
      logic core_on;
      logic ref_on;
   } power_enables_t;

   // Control-register write carrying the mode bits.
   typedef struct packed {
      logic       write;
      logic [1:0] mode;
   } ctrl_write_t;
endpackage : adc_pm_pkg
`default_nettype wire

// >>> start_pin_sync.sv
// Three-stage synchroniser with edge detection for the conversion-start pin.
`default_nettype none
module start_pin_sync (
   // Clock and reset.
   input  wire logic clk_in,
   input  wire logic arst_n_in,
   // Pin and detected edges.
   input  wire logic pin_in,
   output logic      level_out,
   output logic      fall_out,
   output logic      rise_out
);
   typedef struct packed {
      logic [2:0] stage;
      logic       level;
   } sync_state_t;

   sync_state_t state_ff;
   sync_state_t nxt_state;

   // Stage 0 feeds only stage 1; a change counts once stages 1 and 2 agree.
   always_comb begin
      nxt_state          = state_ff;
      nxt_state.stage    = {state_ff.stage[1:0], pin_in};
      if (state_ff.stage[1] == state_ff.stage[2]) begin
         nxt_state.level = state_ff.stage[2];
      end
   end

   // Pin idles high, so reset to the idle level to avoid a false edge.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_ff <= '{stage: 3'h7, level: 1'b1};
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign level_out = state_ff.level;
   assign fall_out  = state_ff.level & ~nxt_state.level;
   assign rise_out  = ~state_ff.level & nxt_state.level;
endmodule : start_pin_sync
`default_nettype wire

// >>> adc_power_management.sv
// Power management sequencer for a sampling converter.
`default_nettype none
//
// Overview of the sequencer.
// The block keeps one state record: the sequencer state, a shared down counter,
// the power-on flag, the current mode and the registered status and rail outputs.
// One combinational process builds the next record and one clocked process
// registers it, so every output comes straight from a flip-flop.
//
// Power-on path.
// After reset the block waits for the first start pulse. That pulse starts a long
// timeout with busy high. When busy falls, the next start pulse runs the power-on
// calibration, again with busy high. After that every pulse starts a conversion.
// A control write before the first pulse skips the whole power-on path. A write
// during the timeout lets the timeout finish but skips the calibration. A write
// during the calibration does not cut it short.
//
// Conversion path.
// A rising edge of the start pin starts a conversion with busy and converting
// high for a fixed number of cycles. Edges that arrive while busy is high are not
// looked at, so a host that pulses too fast simply loses those pulses.
//
// Power-down paths.
// In the two after-conversion modes the block drops the rails when busy falls.
// The full variant also drops the reference; the partial variant keeps it, which
// costs standing current but keeps the reference usable; the wake time is the same in both.
// A falling edge of the start pin wakes the block, and the wake counter must run
// out before a rising edge is taken. A rise during the wake time is dropped, so
// the host must hold the pin low for at least the wake time.
// Outside the power-on timeout and calibration, which run to their end, the immediate
// full power-down mode drops everything at once, even in the middle of a conversion,
// and the cut conversion leaves no result.
//
// Mode changes.
// The mode register takes the new bits on the edge that completes the write, and
// the sequencer acts on the new mode from the following cycle on. This costs one
// cycle of latency but keeps the state decode off the raw input; the reference enable in power-down is decoded from the written bits.
//
// Start pin.
// The pin comes from the host with no relation to this clock, so it passes a
// three-stage synchroniser. An edge is seen three to four cycles after the pin
// moves, which the host has to allow for when it spaces its pulses.
//
module adc_power_management
   import adc_pm_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYC = adc_pm_pkg::TIMEOUT_CYCLES,
   parameter int unsigned CAL_CYC     = adc_pm_pkg::TIMEOUT_CYCLES,
   parameter int unsigned WAKE_CYC    = adc_pm_pkg::WAKE_CYCLES,
   parameter int unsigned CONV_CYC    = adc_pm_pkg::CONV_CYCLES
) (
   // Clock and reset.
   input  wire logic                     clk_in,
   input  wire logic                     arst_n_in,
   // Start pin from the host, active-low pulse.
   input  wire logic                     conversion_start_pin_in,
   // Control register write from the host interface.
   input  wire adc_pm_pkg::ctrl_write_t  ctrl_in,
   // Status and power outputs.
   output logic                          busy_out,
   output logic                          converting_out,
   output logic                          calibrating_out,
   output adc_pm_pkg::power_enables_t    power_out,
   output logic [1:0]                    power_mode_out
);
   import adc_pm_pkg::*;

   // Parameters must fit the counter and be at least one cycle.
   if (TIMEOUT_CYC < 1 || CAL_CYC < 1 || WAKE_CYC < 1 || CONV_CYC < 1) begin : g_chk
      $error("adc_power_management: cycle counts must be at least one");
   end

   typedef struct packed {
      seq_state_t      st;
      logic [CNT_W-1:0] cnt;
      logic            power_on_armed;
      logic [1:0]      mode;
      logic            busy;
      logic            converting;
      logic            calibrating;
      power_enables_t  pwr;
   } pm_state_t;

   pm_state_t state_ff;
   pm_state_t nxt_state;
   logic      start_fall;
   logic      start_rise;

   // Pin arrives from outside the clock domain, so it is synchronised first.
   start_pin_sync u_sync (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .pin_in    (conversion_start_pin_in),
      .level_out (),
      .fall_out  (start_fall),
      .rise_out  (start_rise)
   );

   // Sequencer next state.
   always_comb begin
      nxt_state = state_ff;
      // The write completes on this edge; the new mode governs from the next cycle.
      if (ctrl_in.write) begin
         nxt_state.mode = ctrl_in.mode;
      end
      case (state_ff.st)
         // Waiting for the first start pulse after reset.
         // A control write here disarms the power-on path for good.
         // The first rise instead starts the long timeout with busy high.
         ST_WAIT_FIRST: begin
            if (ctrl_in.write) begin
               nxt_state.power_on_armed = 1'b0;
               nxt_state.st             = ST_IDLE;
            end else if (start_rise) begin
               nxt_state.st   = ST_TIMEOUT;
               nxt_state.cnt  = CNT_W'(TIMEOUT_CYC - 1);
               nxt_state.busy = 1'b1;
            end
         end
         // Power-on timeout running; busy stays high until the counter runs out.
         // A write seen on the last cycle still counts as before the calibration,
         // so it is folded into the exit decision as well as into the flag.
         ST_TIMEOUT: begin
            // A write here still lets the timeout run, but skips calibration.
            if (ctrl_in.write) begin
               nxt_state.power_on_armed = 1'b0;
            end
            if (state_ff.cnt == '0) begin
               nxt_state.busy = 1'b0;
               nxt_state.st   = (state_ff.power_on_armed && !ctrl_in.write) ?
                                ST_WAIT_CAL : ST_IDLE;
            end else begin
               nxt_state.cnt = state_ff.cnt - 1'b1;
            end
         end
         // Timeout over, waiting for the pulse that starts the calibration.
         // A write now disarms the calibration and leaves for normal operation.
         ST_WAIT_CAL: begin
            if (ctrl_in.write) begin
               nxt_state.power_on_armed = 1'b0;
               nxt_state.st             = ST_IDLE;
            end else if (start_rise) begin
               nxt_state.st          = ST_CAL;
               nxt_state.cnt         = CNT_W'(CAL_CYC - 1);
               nxt_state.busy        = 1'b1;
               nxt_state.calibrating = 1'b1;
            end
         end
         // Power-on calibration running with busy and calibrating high.
         // The power-on flag is cleared on the way out so it never runs twice.
         ST_CAL: begin
            // A write during calibration does not abort it.
            if (state_ff.cnt == '0) begin
               nxt_state.busy           = 1'b0;
               nxt_state.calibrating    = 1'b0;
               nxt_state.power_on_armed = 1'b0;
               nxt_state.st             = ST_IDLE;
            end else begin
               nxt_state.cnt = state_ff.cnt - 1'b1;
            end
         end
         // Powered up and ready for a conversion.
         // The immediate power-down mode is checked first so it wins over a pulse.
         ST_IDLE: begin
            if (state_ff.mode == PM_FULL_NOW) begin
               nxt_state.st = ST_DOWN;
            end else if (start_rise) begin
               nxt_state.st         = ST_CONVERT;
               nxt_state.cnt        = CNT_W'(CONV_CYC - 1);
               nxt_state.busy       = 1'b1;
               nxt_state.converting = 1'b1;
            end
         end
         // Rails are off; the reference may still be on in the partial mode.
         // Only a wake edge or a change back to normal operation leaves here.
         ST_DOWN: begin
            // A software change to mode 00, or a wake edge in an after-conversion mode.
            if (state_ff.mode == PM_NORMAL || (state_ff.mode != PM_FULL_NOW && start_fall)) begin
               nxt_state.st  = ST_WAKE;
               nxt_state.cnt = CNT_W'(WAKE_CYC - 1);
            end
         end
         // Rails back on and settling for the wake time.
         // A rise is only taken once the counter has reached zero.
         ST_WAKE: begin
            // Ready after the wake time; a rising edge too early is the host's fault.
            if (state_ff.mode == PM_FULL_NOW) begin
               nxt_state.st = ST_DOWN;
            end else if (state_ff.cnt == '0) begin
               nxt_state.st = ST_IDLE;
            end else begin
               nxt_state.cnt = state_ff.cnt - 1'b1;
            end
            if (start_rise && state_ff.cnt == '0) begin
               nxt_state.st         = ST_CONVERT;
               nxt_state.cnt        = CNT_W'(CONV_CYC - 1);
               nxt_state.busy       = 1'b1;
               nxt_state.converting = 1'b1;
            end
         end
         // Conversion running with busy and converting high.
         // At the end the mode decides whether the rails stay up or drop.
         // The immediate power-down mode cuts the conversion short.
         ST_CONVERT: begin
            // Start pulses during busy are simply not looked at here.
            if (state_ff.mode == PM_FULL_NOW) begin
               nxt_state.st         = ST_DOWN;
               nxt_state.busy       = 1'b0;
               nxt_state.converting = 1'b0;
            end else if (state_ff.cnt == '0) begin
               nxt_state.busy       = 1'b0;
               nxt_state.converting = 1'b0;
               nxt_state.st         = (state_ff.mode == PM_FULL_AFTER ||
                                       state_ff.mode == PM_PART_AFTER) ? ST_DOWN : ST_IDLE;
            end else begin
               nxt_state.cnt = state_ff.cnt - 1'b1;
            end
         end
         // The state type has no unused codes; an unknown state recovers to the ready state.
         default: begin
            nxt_state.st = ST_IDLE;
         end
      endcase
      // Rail enables follow the state: partial keeps the reference alive.
      // They are decoded from the next state so that they change on the same edge
      // as busy, and no cycle shows busy low with the rails still in the old state.
      if (nxt_state.st == ST_DOWN) begin
         nxt_state.pwr.core_on = 1'b0;
         nxt_state.pwr.ref_on  = (nxt_state.mode == PM_PART_AFTER);
      end else begin
         nxt_state.pwr.core_on = 1'b1;
         nxt_state.pwr.ref_on  = 1'b1;
      end
   end

   // State register.
   // Reset puts the block on the power-on path with rails on and mode normal.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_ff <= '{st: ST_WAIT_FIRST, cnt: '0, power_on_armed: 1'b1,
                       mode: PM_RESET_VAL, busy: 1'b0, converting: 1'b0,
                       calibrating: 1'b0, pwr: '{core_on: 1'b1, ref_on: 1'b1}};
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Outputs are plain copies of the registered record, with no logic behind them.
   assign busy_out        = state_ff.busy;
   assign converting_out  = state_ff.converting;
   assign calibrating_out = state_ff.calibrating;
   assign power_out       = state_ff.pwr;
   assign power_mode_out  = state_ff.mode;
endmodule : adc_power_management
`default_nettype wire

// >>> adc_pm_sva.sv
// Port checker for the converter power sequencer.
`default_nettype none
module adc_pm_sva
   import adc_pm_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYC = 50,
   parameter int unsigned CAL_CYC     = 50,
   parameter int unsigned WAKE_CYC    = 5,
   parameter int unsigned CONV_CYC    = 8
) (
   // Clock and reset.
   input wire logic                       clk_in,
   input wire logic                       arst_n_in,
   // Host side.
   input wire logic                       conversion_start_pin_in,
   input wire adc_pm_pkg::ctrl_write_t    ctrl_in,
   // Device outputs.
   input wire logic                       busy_out,
   input wire logic                       converting_out,
   input wire logic                       calibrating_out,
   input wire adc_pm_pkg::power_enables_t power_out,
   input wire logic [1:0]                 power_mode_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] conv_cnt_ff;
   logic [31:0] cal_cnt_ff;
   // Counters hold the high time of a level in the cycle where it falls.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         conv_cnt_ff <= '0;
         cal_cnt_ff  <= '0;
      end else begin
         conv_cnt_ff <= converting_out ? conv_cnt_ff + 32'h1 : '0;
         cal_cnt_ff  <= calibrating_out ? cal_cnt_ff + 32'h1 : '0;
      end
   end
   default clocking dc @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   // A conversion end that an immediate power-down did not cut short.
   sequence s_conv_done;
      $fell(converting_out) ##0 (power_mode_out != PM_FULL_NOW);
   endsequence
   chk_mode_update: assert property (
      ctrl_in.write |=> power_mode_out == $past(ctrl_in.mode)) else $error("mode not taken");
   chk_full_now: assert property (
      ctrl_in.write && ctrl_in.mode == PM_FULL_NOW |-> ##[1:2]
      (!power_out.core_on && !power_out.ref_on && !busy_out)) else $error("no full down");
   chk_ref_core: assert property (
      !power_out.ref_on |-> !power_out.core_on) else $error("core on without reference");
   chk_part_sleep: assert property (
      s_conv_done ##0 power_mode_out == PM_PART_AFTER |-> ##[0:1]
      (!power_out.core_on && power_out.ref_on)) else $error("partial sleep wrong");
   chk_full_sleep: assert property (
      s_conv_done ##0 power_mode_out == PM_FULL_AFTER |-> ##[0:1]
      (!power_out.core_on && !power_out.ref_on)) else $error("full sleep wrong");
   chk_conv_len: assert property (
      s_conv_done |-> conv_cnt_ff == CONV_CYC) else $error("conversion length wrong");
   chk_cal_len: assert property (
      $fell(calibrating_out) |-> cal_cnt_ff == CAL_CYC) else $error("calibration length wrong");
   chk_busy_cover: assert property (
      converting_out || calibrating_out |-> busy_out) else $error("busy low while working");
   chk_wake_quiet: assert property (
      $rose(power_out.core_on) |-> !busy_out [*4]) else $error("busy during wake time");
endmodule : adc_pm_sva
`default_nettype wire

// >>> host_model.sv
// Host model driving the start pin and the control writes.
`default_nettype none
module host_model
   import adc_pm_pkg::*;
(
   // Clock.
   input  wire logic       clk_in,
   // Pin and control write toward the device.
   output var logic        pin_out,
   output var ctrl_write_t ctrl_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle pin is high; the mode lines carry junk outside a write.
   initial begin
      pin_out = 1'b1;
      ctrl_out = '0;
   end
   task automatic write_mode(input logic [1:0] m);
      @(posedge clk_in);
      ctrl_out <= {1'b1, m};
      @(posedge clk_in);
      ctrl_out <= {1'b0, ~m};
   endtask : write_mode
   // Low time must cover the wake time, or the rise is lost.
   task automatic pulse(input int low_cyc);
      @(posedge clk_in);
      pin_out <= 1'b0;
      repeat (low_cyc) @(posedge clk_in);
      pin_out <= 1'b1;
   endtask : pulse
endmodule : host_model
`default_nettype wire

// >>> adc_power_management_tb.sv
// Self-checking bench for the converter power sequencer.
`default_nettype none
module adc_power_management_tb;
   import adc_pm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned T_CYC = 50;
   localparam int unsigned W_CYC = 5;
   localparam int unsigned C_CYC = 8;
   logic           clk_in, arst_n_in, pin, busy_out, converting_out, calibrating_out;
   ctrl_write_t    ctrl;
   power_enables_t power_out;
   logic [1:0]     power_mode_out;
   logic [17:0]    exp_q[$];
   int             n_mismatch = 0, n_tests = 0, busy_len = 0, cyc = 0, seed = 80;
   logic [1:0]     modes[4] = '{PM_NORMAL, PM_FULL_AFTER, PM_PART_AFTER, PM_FULL_AFTER};
   adc_power_management #(.TIMEOUT_CYC(T_CYC), .CAL_CYC(T_CYC), .WAKE_CYC(W_CYC),
      .CONV_CYC(C_CYC)) u_adc_power_management (.clk_in(clk_in), .arst_n_in(arst_n_in),
      .conversion_start_pin_in(pin), .ctrl_in(ctrl), .busy_out(busy_out),
      .converting_out(converting_out), .calibrating_out(calibrating_out),
      .power_out(power_out), .power_mode_out(power_mode_out));
   host_model u_host_model (.clk_in(clk_in), .pin_out(pin), .ctrl_out(ctrl));
   task automatic check_level(input logic [17:0] got, input logic [17:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_level
   // Busy episode: power after the fall and length; a zero length is not compared.
   task automatic check_busy(input logic [17:0] got, input logic [17:0] exp);
      check_level((exp[15:0] == 16'h0) ? {got[17:16], 16'h0} : got, exp);
   endtask : check_busy
   task automatic report_and_stop();
      $display("TB: checks=%0d mismatches=%0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop
   // Waiting here also spaces the starts, keeping the rate low.
   task automatic idle_wait();
      repeat (8) @(posedge clk_in);
      while (busy_out !== 1'b0) @(posedge clk_in);
      repeat (3) @(posedge clk_in);
   endtask : idle_wait
   function automatic logic [1:0] pw_after(input logic [1:0] m);
      return (m == PM_NORMAL) ? 2'h3 : (m == PM_PART_AFTER) ? 2'h1 : 2'h0;
   endfunction : pw_after
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // Watcher: every busy episode is matched against the oldest note; also the hang limit.
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
      if (busy_out === 1'b1) busy_len++;
      else if (busy_len != 0) begin
         if (exp_q.size() == 0) check_busy({power_out, 16'(busy_len)}, 18'h3FFFF);
         else check_busy({power_out, 16'(busy_len)}, exp_q.pop_front());
         busy_len = 0;
      end
   end
   // Main sequence: power-on path, early write, immediate down, modes, short pulse.
   initial begin
      arst_n_in = 1'b0;
      repeat (12) @(posedge clk_in);
      arst_n_in <= 1'b1;
      exp_q.push_back({2'h3, 16'(T_CYC)});
      u_host_model.pulse(8);
      repeat (6) @(posedge clk_in);
      u_host_model.pulse(8);
      idle_wait();
      exp_q.push_back({2'h3, 16'(T_CYC)});
      u_host_model.pulse(8);
      repeat (8) @(posedge clk_in);
      check_level({16'h0, calibrating_out, busy_out}, 18'h3);
      idle_wait();
      exp_q.push_back({2'h3, 16'(C_CYC)});
      u_host_model.pulse(8);
      idle_wait();
      arst_n_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      arst_n_in <= 1'b1;
      u_host_model.write_mode(PM_NORMAL);
      exp_q.push_back({2'h3, 16'(C_CYC)});
      u_host_model.pulse(8);
      idle_wait();
      exp_q.push_back({2'h0, 16'h0});
      u_host_model.pulse(8);
      repeat (5) @(posedge clk_in);
      u_host_model.write_mode(PM_FULL_NOW);
      repeat (2) @(posedge clk_in);
      check_level({15'h0, power_out, busy_out}, 18'h0);
      u_host_model.write_mode(PM_NORMAL);
      repeat (W_CYC + 3) @(posedge clk_in);
      check_level({16'h0, power_out}, 18'h3);
      foreach (modes[i]) begin
         u_host_model.write_mode(modes[i]);
         @(negedge clk_in);
         check_level({16'h0, power_mode_out}, {16'h0, modes[i]});
         exp_q.push_back({pw_after(modes[i]), 16'(C_CYC)});
         u_host_model.pulse(W_CYC + 8 + ($unsigned($random(seed)) % 8));
         idle_wait();
      end
      u_host_model.pulse(2);
      repeat (12) @(posedge clk_in);
      check_level({16'h0, power_out.core_on, busy_out}, 18'h2);
      report_and_stop();
   end
endmodule : adc_power_management_tb
bind adc_power_management adc_pm_sva #(.TIMEOUT_CYC(TIMEOUT_CYC), .CAL_CYC(CAL_CYC),
   .WAKE_CYC(WAKE_CYC), .CONV_CYC(CONV_CYC)) u_adc_pm_sva (.clk_in(clk_in),
   .arst_n_in(arst_n_in), .conversion_start_pin_in(conversion_start_pin_in),
   .ctrl_in(ctrl_in), .busy_out(busy_out), .converting_out(converting_out),
   .calibrating_out(calibrating_out), .power_out(power_out),
   .power_mode_out(power_mode_out));
`default_nettype wire
